// File: src/vic_pkg.sv
// Purpose: Shared constants for the vectored priority interrupt controller
// Assumes: APB byte address is four times the register index
// Notes:   Slot numbers rise as fixed priority falls

package vic_pkg;

  // Priority slots; vector address = VEC_BASE + 2 * slot
  localparam int N_SLOTS    = 27;
  localparam int SLOT_RESET = 0;
  localparam int SLOT_WDT   = 1;
  localparam int SLOT_TRAP  = 2;
  localparam int SLOT_G0    = 3;
  localparam int SLOT_PIN   = 11;
  localparam int SLOT_G1    = 19;
  localparam int SLOT_T3    = 19;
  localparam int SLOT_PC    = 23;
  localparam int SLOT_AUX   = 11;

  localparam logic [15:0] VEC_BASE = 16'h0002;
  localparam logic [15:0] VEC_WDT  = 16'h0004;
  localparam logic [15:0] VEC_TRAP = 16'h0006;

  // Levels seen by the arbiter; zero never wins
  localparam logic [2:0] LVL_OFF     = 3'h0;
  localparam logic [2:0] LVL_NOMINAL = 3'h2;
  localparam logic [2:0] LVL_NMI     = 3'h4;

  // Register indices
  localparam logic [11:0] IDX_PEND  = 12'hfc0;
  localparam logic [11:0] IDX_ENH   = 12'hfc1;
  localparam logic [11:0] IDX_ENL   = 12'hfc2;
  localparam logic [11:0] IDX_AUX   = 12'hfc3;
  localparam logic [11:0] IDX_PSEL  = 12'hfc4;
  localparam logic [11:0] IDX_CTRL  = 12'hfc5;
  localparam logic [11:0] IDX_MASK  = 12'hfc6;
  localparam logic [11:0] IDX_VEC   = 12'hfc7;

  localparam logic [15:0] ADDR_PEND = {2'h0, IDX_PEND, 2'h0};
  localparam logic [15:0] ADDR_ENH  = {2'h0, IDX_ENH, 2'h0};
  localparam logic [15:0] ADDR_ENL  = {2'h0, IDX_ENL, 2'h0};
  localparam logic [15:0] ADDR_AUX  = {2'h0, IDX_AUX, 2'h0};
  localparam logic [15:0] ADDR_PSEL = {2'h0, IDX_PSEL, 2'h0};
  localparam logic [15:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [15:0] ADDR_MASK = {2'h0, IDX_MASK, 2'h0};
  localparam logic [15:0] ADDR_VEC  = {2'h0, IDX_VEC, 2'h0};

  // Control register fields
  localparam int CTRL_GIE       = 0;
  localparam int CTRL_WDT_EN    = 1;
  localparam int CTRL_SMALL_PKG = 2;

  // Vector readback fields
  localparam int VRD_SLOT_LSB = 16;
  localparam int VRD_IRQ      = 31;

  // Reset values
  localparam logic [7:0]  RST_ENH  = 8'h00;
  localparam logic [7:0]  RST_ENL  = 8'h00;
  localparam logic [15:0] RST_AUX  = 16'h0000;
  localparam logic [7:0]  RST_PSEL = 8'h00;
  localparam logic [2:0]  RST_CTRL = 3'h0;
  localparam logic [26:0] RST_MASK = 27'h0000000;
  localparam logic [26:0] RST_PEND = 27'h0000001;

endpackage

// File: src/vic_sync_edge.sv
// Purpose: Two-stage synchroniser with any-edge detect per pin
// Assumes: Pins are asynchronous to pclk
// Notes:   Edges are held off until both stages carry real pin data

module vic_sync_edge #(
  parameter int W = 20
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Pins and edges
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] edge_any
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [2:0]   arm_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      arm_r <= 3'h0;
    end
    else
    begin
      s1_r  <= pin;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      arm_r <= {arm_r[1:0], 1'b1};
    end
  end

  // Reset value of the stages would otherwise look like an edge
  assign edge_any = (s2_r ^ s3_r) & {W{arm_r[2]}};

endmodule

// File: src/vic_arbiter.sv
// Purpose: Pick the pending slot with the highest level
// Assumes: Level zero means not eligible
// Notes:   Equal levels go to the lowest slot number

module vic_arbiter #(
  parameter int N = 27
) (
  // Requests
  input  wire logic [N-1:0]      req,
  input  wire logic [N-1:0][2:0] lvl,
  // Winner
  output logic                   found,
  output logic      [4:0]        idx,
  output logic      [2:0]        win_lvl
);

  always_comb
  begin
    found   = 1'b0;
    idx     = 5'h00;
    win_lvl = 3'h0;
    // Walk downward so that ties settle on the lower slot
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i] && lvl[i] != 3'h0 && lvl[i] >= win_lvl)
      begin
        found   = 1'b1;
        idx     = 5'(i);
        win_lvl = lvl[i];
      end
    end
  end

endmodule

// File: src/vic_top.sv
// Purpose: Vectored priority interrupt controller with APB registers
// Assumes: Request strobes are on pclk; port pins are asynchronous
// Notes:   Vector presented one cycle after arbitration settles
//
// Notes on behaviour
// (R01) Reset entry highest, vector 0002H, unmaskable
// (R02) Watchdog uses vector 0004H after reset
// (R03) Trap uses 0006H, unmaskable, above peripherals
// (R04) Peripherals ordered by vector, two bytes apart
// (R05) Port A/D bit shares vector, any edge
// (R06) Port C pins lowest, both edges each
// (R07) Timer 3 slot unused in small package
// (R08) High and low bits form level code
// (R09) Code 00 off, 01 low, 10 nominal, 11 high
// (R10) High enable bits map timer2 down to converter
// (R11) High enable register RW, resets to zero
// (R12) Highest level wins, ties by vector order

module vic_top
  import vic_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Peripheral request strobes
  input  wire logic        wdt_req,
  input  wire logic        trap_req,
  input  wire logic [7:0]  grp0_req,
  input  wire logic [3:0]  grp1_req,
  // Port pins
  input  wire logic [7:0]  port_a,
  input  wire logic [7:0]  port_d,
  input  wire logic [3:0]  port_c,
  // CPU vector side
  input  wire logic        cpu_ack,
  output logic             cpu_irq,
  output logic      [15:0] cpu_vector,
  // Status interrupt
  output logic             sys_irq
);

  import vic_pkg::*;

  localparam int N = N_SLOTS;

  // Registers
  logic [7:0]  enh_r;
  logic [7:0]  enl_r;
  logic [15:0] aux_r;
  logic [7:0]  psel_r;
  logic [2:0]  ctrl_r;
  logic [N-1:0] mask_r;
  logic [N-1:0] pend_r;
  logic [N-1:0] pend_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic [15:0] vec_r;
  logic [15:0] vec_nxt;
  logic [4:0]  slot_r;
  logic        sys_irq_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  // Pin edges
  logic [19:0] pin_edge;
  logic [7:0]  a_edge;
  logic [7:0]  d_edge;
  logic [3:0]  c_edge;
  logic [7:0]  ad_edge;

  vic_sync_edge #(
    .W (20)
  ) u_pins (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin      ({port_c, port_d, port_a}),
    .edge_any (pin_edge)
  );

  assign a_edge = pin_edge[7:0];
  assign d_edge = pin_edge[15:8];
  assign c_edge = pin_edge[19:16];

  // Each shared vector listens to one port of the pair
  assign ad_edge = (psel_r & d_edge) | (~psel_r & a_edge); // [R05]

  // Control decode
  wire gie       = ctrl_r[CTRL_GIE];
  wire wdt_en    = ctrl_r[CTRL_WDT_EN];
  wire small_pkg = ctrl_r[CTRL_SMALL_PKG];

  // Event set vector in slot order
  logic [N-1:0] set_v;

  assign set_v[SLOT_RESET] = 1'b0;
  assign set_v[SLOT_WDT]   = wdt_req;  // [R02]
  assign set_v[SLOT_TRAP]  = trap_req; // [R03]

  for (genvar b = 0; b < 8; b++)
  begin : g_set8
    assign set_v[SLOT_G0 + 7 - b]  = grp0_req[b]; // [R04] [R10]
    assign set_v[SLOT_PIN + 7 - b] = ad_edge[b];  // [R05]
  end

  for (genvar b = 0; b < 4; b++)
  begin : g_set4
    if (SLOT_G1 + 3 - b == SLOT_T3)
    begin : g_t3
      // Timer 3 is absent in the small package
      assign set_v[SLOT_T3] = grp1_req[b] & ~small_pkg; // [R07]
    end
    else
    begin : g_g1
      assign set_v[SLOT_G1 + 3 - b] = grp1_req[b]; // [R04]
    end
    assign set_v[SLOT_PC + 3 - b] = c_edge[b]; // [R06]
  end

  // Levels per slot
  logic [N-1:0][2:0] lvl;

  // Reset entry and trap ignore every enable
  assign lvl[SLOT_RESET] = LVL_NMI; // [R01]
  assign lvl[SLOT_TRAP]  = LVL_NMI; // [R03]
  assign lvl[SLOT_WDT]   = (gie && wdt_en) ? LVL_NMI : LVL_OFF; // [R02]

  for (genvar j = 0; j < 8; j++)
  begin : g_lvl0
    // Code {high, low}: 00 off, 01 low, 10 nominal, 11 high
    assign lvl[SLOT_G0 + j] =
      gie ? {1'b0, enh_r[7 - j], enl_r[7 - j]} : LVL_OFF; // [R08] [R09]
  end

  for (genvar k = 0; k < 16; k++)
  begin : g_lvl1
    assign lvl[SLOT_AUX + k] =
      (gie && aux_r[k]) ? LVL_NOMINAL : LVL_OFF;
  end

  // Arbitration
  logic       win_found;
  logic [4:0] win_idx;
  logic [2:0] win_lvl;

  vic_arbiter #(
    .N (N)
  ) u_arb (
    .req     (pend_r),
    .lvl     (lvl),
    .found   (win_found),
    .idx     (win_idx),
    .win_lvl (win_lvl)
  );

  // A cycle of silence after each acknowledge stops a stale repeat
  assign irq_nxt = win_found && !(cpu_ack && irq_r); // [R12]
  assign vec_nxt = VEC_BASE + {10'h000, win_idx, 1'b0}; // [R04]

  // APB decode
  wire setup   = psel && !penable;
  wire wr_go   = psel && penable && pready_r && pwrite;
  wire aligned = paddr[1:0] == 2'h0;
  wire hit_pend = aligned && paddr == ADDR_PEND;
  wire hit_enh  = aligned && paddr == ADDR_ENH;
  wire hit_enl  = aligned && paddr == ADDR_ENL;
  wire hit_aux  = aligned && paddr == ADDR_AUX;
  wire hit_psel = aligned && paddr == ADDR_PSEL;
  wire hit_ctrl = aligned && paddr == ADDR_CTRL;
  wire hit_mask = aligned && paddr == ADDR_MASK;
  wire hit_vec  = aligned && paddr == ADDR_VEC;
  wire hit_any  = hit_pend || hit_enh || hit_enl || hit_aux ||
                  hit_psel || hit_ctrl || hit_mask || hit_vec;

  wire [31:0] vec_rd = {irq_r, 10'h000, slot_r, vec_r};

  wire [31:0] rd_mux =
    hit_pend ? {5'h00, pend_r} :
    hit_enh  ? {24'h000000, enh_r} :
    hit_enl  ? {24'h000000, enl_r} :
    hit_aux  ? {16'h0000, aux_r} :
    hit_psel ? {24'h000000, psel_r} :
    hit_ctrl ? {29'h00000000, ctrl_r} :
    hit_mask ? {5'h00, mask_r} :
    hit_vec  ? vec_rd : 32'h00000000;

  // Clears: software write-one and CPU acknowledge
  wire [N-1:0] clr_sw  = (wr_go && hit_pend) ? pwdata[N-1:0] : '0;
  wire [N-1:0] clr_ack = (cpu_ack && irq_r) ? (N'(1) << slot_r) : '0;

  // New events win over a clear in the same cycle
  assign pend_nxt = (pend_r & ~clr_sw & ~clr_ack) | set_v;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_r <= RST_PEND; // [R01]
    else
      pend_r <= pend_nxt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enh_r  <= RST_ENH; // [R11]
      enl_r  <= RST_ENL;
      aux_r  <= RST_AUX;
      psel_r <= RST_PSEL;
      ctrl_r <= RST_CTRL;
      mask_r <= RST_MASK;
    end
    else
    begin
      if (wr_go && hit_enh)
        enh_r <= pwdata[7:0]; // [R10] [R11]
      if (wr_go && hit_enl)
        enl_r <= pwdata[7:0]; // [R08]
      if (wr_go && hit_aux)
        aux_r <= pwdata[15:0];
      if (wr_go && hit_psel)
        psel_r <= pwdata[7:0];
      if (wr_go && hit_ctrl)
        ctrl_r <= pwdata[2:0];
      if (wr_go && hit_mask)
        mask_r <= pwdata[N-1:0];
    end
  end

  // Vector side; outputs all from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_r     <= 1'b0;
      vec_r     <= VEC_BASE;
      slot_r    <= 5'h00;
      sys_irq_r <= 1'b0;
    end
    else
    begin
      irq_r     <= irq_nxt; // [R12]
      vec_r     <= vec_nxt;
      slot_r    <= win_idx;
      sys_irq_r <= |(pend_r & mask_r);
    end
  end

  // Read data is captured in setup, so the access phase never waits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= setup;
      pslverr_r <= setup && !hit_any;
      if (setup && !pwrite)
        prdata_r <= rd_mux;
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign cpu_irq    = irq_r;
  assign cpu_vector = vec_r;
  assign sys_irq    = sys_irq_r;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [2:0] max_lvl;
  always_comb
  begin
    max_lvl = 3'h0;
    for (int i = 0; i < N; i++)
      if (pend_r[i] && lvl[i] > max_lvl)
        max_lvl = lvl[i];
  end

  a_reset_entry: assert property ( // [R01]
    irq_r && $past(pend_r[SLOT_RESET]) |-> vec_r == VEC_BASE)
    else $error("reset entry not presented first");

  a_wdt_vector: assert property ( // [R02]
    irq_r && $past(pend_r[2:0]) == 3'h2 && $past(gie && wdt_en)
    |-> vec_r == VEC_WDT)
    else $error("watchdog vector wrong");

  a_trap_above: assert property ( // [R03]
    irq_r && $past(pend_r[SLOT_TRAP]) |-> vec_r <= VEC_TRAP)
    else $error("trap lost to a peripheral");

  a_vec_spacing: assert property ( // [R04]
    irq_r |-> vec_r == VEC_BASE + {10'h000, slot_r, 1'b0})
    else $error("vector not two bytes per slot");

  a_pin_pending: assert property ( // [R05]
    ad_edge[7] |=> pend_r[SLOT_PIN])
    else $error("port pin edge not pending");

  a_portc_pending: assert property ( // [R06]
    c_edge[0] |=> pend_r[SLOT_PC + 3])
    else $error("port c edge not pending");

  a_t3_absent: assert property ( // [R07]
    small_pkg && !pend_r[SLOT_T3] |=> !pend_r[SLOT_T3])
    else $error("timer 3 pending in small package");

  a_code_off: assert property ( // [R09]
    irq_r && slot_r >= 5'(SLOT_G0) && slot_r < 5'(SLOT_PIN)
    |-> ($past(enh_r | enl_r) & (8'h80 >> (slot_r - 5'(SLOT_G0))))
        != 8'h00)
    else $error("disabled source presented");

  a_enh_write: assert property ( // [R11]
    wr_go && hit_enh |=> enh_r == $past(pwdata[7:0]))
    else $error("high enable write lost");

  a_level_wins: assert property ( // [R12]
    irq_r |-> $past(max_lvl) == $past(win_lvl))
    else $error("lower level won arbitration");

  a_ack_drops: assert property (
    cpu_ack && irq_r |=> !irq_r)
    else $error("request held after acknowledge");

  c_ack_seen: cover property (cpu_ack && irq_r);
  c_level3: cover property (irq_r && $past(win_lvl) == 3'h3);
  c_set_clr: cover property (wr_go && hit_pend && |(set_v & pwdata[N-1:0]));
  c_unmapped: cover property (pready_r && pslverr_r);

endmodule

// File: sim/vic_cpu_model.sv
// Purpose: CPU core stand-in that takes presented vectors
// Assumes: One ack pulse per presented request, sampled on pclk
// Notes:   Ack delay is set by the bench to answer fast or slow

module vic_cpu_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Vector side
  input  wire logic        cpu_irq,
  input  wire logic [15:0] cpu_vector,
  input  wire logic [3:0]  ack_dly,
  output logic             cpu_ack,
  // Record of taken vectors
  output logic      [15:0] last_vec,
  output logic      [7:0]  n_taken
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] wait_r;

  // The vector is captured at the edge that samples the ack, as it may
  // change while the ack is being raised
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_ack  <= 1'b0;
      wait_r   <= 4'h0;
      last_vec <= 16'h0;
      n_taken  <= 8'h0;
    end
    else
    begin
      if (cpu_ack && cpu_irq)
      begin
        last_vec <= cpu_vector;
        n_taken  <= n_taken + 8'h1;
      end
      if (cpu_irq && !cpu_ack && wait_r >= ack_dly)
      begin
        cpu_ack <= 1'b1;
        wait_r  <= 4'h0;
      end
      else
      begin
        cpu_ack <= 1'b0;
        wait_r  <= (cpu_irq && !cpu_ack) ? wait_r + 4'h1 : 4'h0;
      end
    end
  end
endmodule

// File: sim/vic_top_tb.sv
// Purpose: Self-checking bench for the interrupt controller
// Assumes: APB slave answers in its own time; CPU model acks vectors
// Notes:   Several requests are raised at once to exercise arbitration

module vic_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import vic_pkg::*;

  logic        pclk     = 1'b0;
  logic        presetn  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [15:0] paddr    = 16'h0;
  logic [31:0] pwdata   = 32'h0;
  logic        wdt_req  = 1'b0;
  logic        trap_req = 1'b0;
  logic [7:0]  grp0_req = 8'h0;
  logic [3:0]  grp1_req = 4'h0;
  logic [7:0]  port_a   = 8'h0;
  logic [7:0]  port_d   = 8'h0;
  logic [3:0]  port_c   = 4'h0;
  logic [3:0]  ack_dly  = 4'h2;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cpu_ack;
  logic        cpu_irq;
  logic [15:0] cpu_vector;
  logic        sys_irq;
  logic [15:0] last_vec;
  logic [7:0]  n_taken;
  logic [7:0]  seen     = 8'h0;
  logic [31:0] rdata;
  logic        rerr;
  int          failures = 0;
  int          total_checks = 0;

  always #4 pclk = ~pclk;

  vic_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wdt_req(wdt_req),
    .trap_req(trap_req), .grp0_req(grp0_req), .grp1_req(grp1_req),
    .port_a(port_a), .port_d(port_d), .port_c(port_c),
    .cpu_ack(cpu_ack), .cpu_irq(cpu_irq), .cpu_vector(cpu_vector),
    .sys_irq(sys_irq)
  );

  vic_cpu_model cpu (
    .pclk(pclk), .presetn(presetn), .cpu_irq(cpu_irq),
    .cpu_vector(cpu_vector), .ack_dly(ack_dly), .cpu_ack(cpu_ack),
    .last_vec(last_vec), .n_taken(n_taken)
  );

  task automatic chk(input string what, input logic [31:0] got,
                     input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request held until pready is seen at a rising edge; data taken there
  task automatic apb(input logic wr, input logic [15:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    chk("pready", 32'(pready), 32'h1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input logic w, input logic t, input logic [7:0] g0,
                       input logic [3:0] g1);
    @(posedge pclk);
    wdt_req  <= w;
    trap_req <= t;
    grp0_req <= g0;
    grp1_req <= g1;
    @(posedge pclk);
    wdt_req  <= 1'b0;
    trap_req <= 1'b0;
    grp0_req <= 8'h0;
    grp1_req <= 4'h0;
  endtask

  task automatic take(input logic [15:0] exp);
    int n;
    n = 0;
    while (n_taken === seen && n < 100)
    begin
      @(negedge pclk);
      n++;
    end
    chk("vector count", 32'(n_taken), 32'(seen + 8'h1));
    seen = seen + 8'h1;
    chk("vector", 32'(last_vec), 32'(exp));
  endtask

  task automatic none();
    repeat (30) @(negedge pclk);
    chk("taken count", 32'(n_taken), 32'(seen));
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    $display("ERROR run expected done seen hang");
    conclude();
  end

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    take(VEC_BASE);
    apb(1'b0, ADDR_ENH, 32'h0);
    chk("enh reset", rdata, 32'h0);
    apb(1'b1, ADDR_ENH, 32'h5a);
    apb(1'b0, ADDR_ENH, 32'h0);
    chk("enh rw", rdata, 32'h5a);
    apb(1'b0, 16'h0100, 32'h0);
    chk("unmapped", 32'(rerr), 32'h1);
    $display("test reset done");
    // Global enable is still off: trap must come through anyway
    pulse(1'b0, 1'b1, 8'h0, 4'h0);
    take(VEC_TRAP);
    apb(1'b1, ADDR_CTRL, 32'h3);
    apb(1'b1, ADDR_ENH, 32'h80);
    apb(1'b1, ADDR_ENL, 32'h80);
    pulse(1'b1, 1'b0, 8'h80, 4'h0);
    take(VEC_WDT);
    take(16'h0008);
    $display("test fixed sources done");
    ack_dly <= 4'h9;
    apb(1'b1, ADDR_ENH, 32'h05);
    apb(1'b1, ADDR_ENL, 32'h06);
    pulse(1'b0, 1'b0, 8'h87, 4'h0);
    take(16'h0012);
    take(16'h0016);
    take(16'h0014);
    none();
    apb(1'b0, ADDR_PEND, 32'h0);
    chk("pending", rdata, 32'h8);
    chk("sys_irq masked", 32'(sys_irq), 32'h0);
    apb(1'b1, ADDR_MASK, 32'h8);
    repeat (2) @(negedge pclk);
    chk("sys_irq set", 32'(sys_irq), 32'h1);
    apb(1'b1, ADDR_PEND, 32'h8);
    repeat (2) @(negedge pclk);
    chk("sys_irq clear", 32'(sys_irq), 32'h0);
    $display("test levels done");
    ack_dly <= 4'h0;
    apb(1'b1, ADDR_ENH, 32'hff);
    apb(1'b1, ADDR_ENL, 32'h00);
    pulse(1'b0, 1'b0, 8'hff, 4'h0);
    for (int i = 0; i < 8; i++)
      take(16'h0008 + 16'(2 * i));
    $display("test group0 order done");
    apb(1'b1, ADDR_AUX, 32'hffff);
    apb(1'b1, ADDR_CTRL, 32'h1);
    pulse(1'b0, 1'b0, 8'h0, 4'hf);
    for (int i = 0; i < 4; i++)
      take(16'h0028 + 16'(2 * i));
    apb(1'b1, ADDR_CTRL, 32'h5);
    pulse(1'b0, 1'b0, 8'h0, 4'h8);
    none();
    $display("test group1 done");
    apb(1'b1, ADDR_PSEL, 32'h01);
    // Rising edges first, then falling edges on the same pins
    for (int k = 0; k < 2; k++)
    begin
      @(posedge pclk);
      port_a <= k ? 8'h00 : 8'h80;
      port_d <= k ? 8'h00 : 8'h01;
      port_c <= k ? 4'h0 : 4'h9;
      take(16'h0018);
      take(16'h0026);
      take(16'h0030);
      take(16'h0036);
    end
    $display("test pins done");
    conclude();
  end
endmodule
